// >>> hw/pfs_pkg.sv
// Constants, register map and state encoding of the point-of-load fault supervisor.
// Assumes a 100 MHz system clock; measurement codes arrive on that same clock.
package pfs_pkg;
  // Clock and timing.
  localparam int CLK_PERIOD_NS = 10;
  localparam int TRIP_DELAY_US = 6;
  localparam int TRIP_DELAY_CYC = (TRIP_DELAY_US * 1000) / CLK_PERIOD_NS;
  localparam int RETRY_PERIOD_MS = 130;
  localparam int RETRY_CYC_DEF = (RETRY_PERIOD_MS * 1000000) / CLK_PERIOD_NS;
  localparam int QUAL_CW = 10;
  localparam int RETRY_CW = 24;
  // Register byte offsets.
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  // Configuration fields.
  localparam int CFG_OC_LSB = 0;
  localparam int CFG_OV_LSB = 4;
  localparam int CFG_UV_LSB = 8;
  localparam int CFG_PGLO_BIT = 12;
  localparam int CFG_LATCH_LSB = 16;
  localparam int CFG_TRK_EN_BIT = 21;
  localparam logic [31:0] CFG_RESET = 32'h0000_0020;
  localparam logic [31:0] CFG_WMASK = 32'h003F_1F3F;
  // Status fields.
  localparam int STAT_ON_BIT = 0;
  localparam int STAT_WARN_BIT = 1;
  localparam int STAT_PG_BIT = 2;
  localparam int STAT_OTBLK_BIT = 3;
  localparam int STAT_STATE_LSB = 8;
  // Event indices, shared by qualifiers and interrupt bits.
  localparam int EV_OC = 0;
  localparam int EV_OV = 1;
  localparam int EV_UV = 2;
  localparam int EV_OT = 3;
  localparam int EV_TRK = 4;
  localparam int EV_WARN = 5;
  localparam int EV_PG = 6;
  localparam int N_FAULT = 5;
  localparam int N_EV = 7;
  // Thresholds.
  localparam int PCT_UNIT = 100;
  localparam int OC_BASE_PCT = 60;
  localparam int OC_STEP_PCT = 12;
  localparam int OC_MAX_CODE = 10;
  localparam int OV_BASE_PCT = 110;
  localparam int OV_STEP_PCT = 10;
  localparam int OV_MAX_CODE = 2;
  localparam int OV_FLOOR_MV = 1000;
  localparam int UV_TOP_PCT = 85;
  localparam int UV_STEP_PCT = 5;
  localparam int PG_HI_PCT = 110;
  localparam int PG_LO_PCT = 90;
  localparam int PG_LO_ALT_PCT = 95;
  localparam int TRK_LIMIT_MV = 250;
  localparam int OT_OFF_C = 130;
  localparam int OT_ON_C = 120;
  localparam int WARN_ON_C = 120;
  localparam int WARN_HYST_C = 3;
  // Output sequencing states.
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_RUN = 2'b01,
    ST_RETRY = 2'b10,
    ST_LATCH = 2'b11
  } pfs_state_e;
endpackage : pfs_pkg

// >>> hw/pfs_qual.sv
// Persistence filter: the output follows the input once it has differed for N cycles.
// Assumes the input is synchronous to clock.
module pfs_qual
  import pfs_pkg::*;
#(
  parameter int unsigned N = TRIP_DELAY_CYC
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Condition in and out.
  input wire logic raw,
  output logic qual
);
  logic [QUAL_CW-1:0] cnt_r;

  // A single sample equal to the output restarts the count, so glitches never propagate.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= '0;
      qual <= 1'b0;
    end else if (raw == qual) begin
      cnt_r <= '0;
    end else if (cnt_r == QUAL_CW'(N - 1)) begin
      cnt_r <= '0;
      qual <= raw;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule : pfs_qual

// >>> hw/pfs_retry_if.sv
// Handshake between the supervisor sequencer and its retry timer.
// Assumes both ends share one clock.
interface pfs_retry_if;
  logic start;
  logic done;
  modport ctl (output start, input done);
  modport tmr (input start, output done);
endinterface : pfs_retry_if

// >>> hw/pfs_retry_timer.sv
// One-shot retry timer; done pulses for one cycle when the period ends.
// Assumes start is a one-cycle pulse; a start while running reloads the count.
module pfs_retry_timer
  import pfs_pkg::*;
#(
  parameter int unsigned CYCLES = RETRY_CYC_DEF
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Sequencer handshake.
  pfs_retry_if.tmr rif
);
  logic [RETRY_CW-1:0] cnt_r;
  logic run_r;

  // Count down from the loaded period; start takes priority over expiry.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end else if (rif.start) begin
      cnt_r <= RETRY_CW'(CYCLES - 1);
      run_r <= 1'b1;
    end else if (run_r) begin
      if (cnt_r == '0) begin
        run_r <= 1'b0;
      end else begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  assign rif.done = run_r && (cnt_r == '0);
endmodule : pfs_retry_timer

// >>> hw/pfs_supervisor.sv
// Fault supervisor of a point-of-load converter: thresholds, trip sequencing, power good.
// Assumes measurement codes come from logic on clock; enable_pin comes from outside.
//
// Notes on behaviour
// [RULE_01] Overcurrent, overvoltage, undervoltage each latching or retrying; retrying by default.
// [RULE_02] Tracking protection off by default; when on, latching or retrying.
// [RULE_03] Overcurrent threshold in 11 steps from 60 to 180 percent rated.
// [RULE_04] Overvoltage threshold 110, 120 or 130 percent of setpoint; 130 default.
// [RULE_05] Overvoltage never trips below 1.0 V output.
// [RULE_06] Undervoltage threshold in 5 percent steps, highest 85 percent.
// [RULE_07] Every fault turns the output off 6 us after crossing.
// [RULE_08] Tracking checked only during ramp up; trips beyond 250 mV error.
// [RULE_09] Overtemperature trips at 130 C; restart allowed only at 120 C.
// [RULE_10] Overtemperature warning always on, set at 120 C, 3 C hysteresis.
// [RULE_11] Warning flag rises 6 us after crossing its threshold.
// [RULE_12] Power good high inside 90 or 95 to 110 percent window.
// [RULE_13] Power good changes 6 us after a window bound is crossed.
// [RULE_14] Latched faults wait for external re-enable; others restart each retry period.
module pfs_supervisor
  import pfs_pkg::*;
#(
  parameter int unsigned RETRY_CYCLES = RETRY_CYC_DEF
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Measurements.
  input wire logic [7:0] iout_pct,
  input wire logic [15:0] vout_mv,
  input wire logic [15:0] vset_mv,
  input wire logic signed [9:0] temp_c,
  input wire logic signed [15:0] track_err_mv,
  input wire logic ramp_up,
  // External enable.
  input wire logic enable_pin,
  // Power stage and system.
  output logic out_on,
  output logic turn_off,
  output logic power_good_out,
  output logic irq
);
  pfs_state_e state_r, state_nxt;
  logic [31:0] cfg_r, irq_stat_r, irq_mask_r, stat_w;
  logic [N_EV-1:0] raw, q, q_d_r, ev;
  logic en_s1_r, en_s2_r, ot_block_r, warn_hyst_r, fault_any, latch_hit;
  logic [3:0] oc_sel, uv_code;
  logic [1:0] ov_sel;
  logic [7:0] oc_thr, ov_pct, uv_pct, pg_lo;
  logic [23:0] vout_x100;
  logic [QUAL_CW-1:0] ov_hold_r, warn_hold_r;
  pfs_retry_if rif ();

  // Millivolts times percent, kept at a width that cannot overflow.
  function automatic logic [23:0] pfs_scale(input logic [15:0] mv, input logic [7:0] pct);
    return 24'(mv) * 24'(pct);
  endfunction : pfs_scale

  // The enable pin is asynchronous; only the second stage is read.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      en_s1_r <= 1'b0;
      en_s2_r <= 1'b0;
    end else begin
      en_s1_r <= enable_pin;
      en_s2_r <= en_s1_r;
    end
  end

  // Threshold decode; out-of-range codes saturate rather than wrap.
  always_comb begin
    oc_sel = (cfg_r[CFG_OC_LSB +: 4] > 4'(OC_MAX_CODE)) ? 4'(OC_MAX_CODE) : cfg_r[CFG_OC_LSB +: 4];
    oc_thr = 8'(OC_BASE_PCT + OC_STEP_PCT * int'(oc_sel)); // RULE_03
    ov_sel = (cfg_r[CFG_OV_LSB +: 2] > 2'(OV_MAX_CODE)) ? 2'(OV_MAX_CODE) : cfg_r[CFG_OV_LSB +: 2];
    ov_pct = 8'(OV_BASE_PCT + OV_STEP_PCT * int'(ov_sel)); // RULE_04
    uv_code = cfg_r[CFG_UV_LSB +: 4];
    uv_pct = 8'(UV_TOP_PCT - UV_STEP_PCT * int'(uv_code)); // RULE_06
    pg_lo = cfg_r[CFG_PGLO_BIT] ? 8'(PG_LO_ALT_PCT) : 8'(PG_LO_PCT); // RULE_12
    vout_x100 = pfs_scale(vout_mv, 8'(PCT_UNIT));
  end

  // Raw conditions. Undervoltage is blind while off or ramping, else every restart trips.
  always_comb begin
    raw[EV_OC] = out_on && (iout_pct >= oc_thr);
    raw[EV_OV] = (vout_x100 >= pfs_scale(vset_mv, ov_pct))
      && (vout_mv >= 16'(OV_FLOOR_MV)); // RULE_05
    raw[EV_UV] = out_on && !ramp_up && (vout_x100 < pfs_scale(vset_mv, uv_pct));
    raw[EV_OT] = temp_c >= 10'(OT_OFF_C); // RULE_09
    raw[EV_TRK] = cfg_r[CFG_TRK_EN_BIT] && out_on && ramp_up
      && ((track_err_mv > 16'(TRK_LIMIT_MV)) || (track_err_mv < 16'(-TRK_LIMIT_MV))); // RULE_08
    raw[EV_WARN] = warn_hyst_r;
    raw[EV_PG] = (vout_x100 >= pfs_scale(vset_mv, pg_lo))
      && (vout_x100 <= pfs_scale(vset_mv, 8'(PG_HI_PCT))); // RULE_12
  end

  // Each condition must persist for the trip delay before it acts.
  for (genvar i = 0; i < N_EV; i++) begin : g_qual
    pfs_qual #(.N(TRIP_DELAY_CYC)) u_qual ( // RULE_07 RULE_11 RULE_13
      .clock(clock),
      .reset_n(reset_n),
      .raw(raw[i]),
      .qual(q[i])
    );
  end
  assign power_good_out = q[EV_PG];

  // Warning comparator with hysteresis; it has no enable, so it always runs.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      warn_hyst_r <= 1'b0;
    end else if (temp_c >= 10'(WARN_ON_C)) begin
      warn_hyst_r <= 1'b1; // RULE_10
    end else if (temp_c <= 10'(WARN_ON_C - WARN_HYST_C)) begin
      warn_hyst_r <= 1'b0; // RULE_10
    end
  end

  // Overtemperature restart lock, released only once the die has cooled.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ot_block_r <= 1'b0;
    end else if (q[EV_OT]) begin
      ot_block_r <= 1'b1; // RULE_09
    end else if (temp_c <= 10'(OT_ON_C)) begin
      ot_block_r <= 1'b0; // RULE_09
    end
  end

  assign fault_any = |q[N_FAULT-1:0];
  assign latch_hit = |(q[N_FAULT-1:0] & cfg_r[CFG_LATCH_LSB +: N_FAULT]); // RULE_01 RULE_02

  // Sequencer; dropping the enable pin overrides everything, which also clears a latch.
  always_comb begin
    state_nxt = state_r;
    rif.start = 1'b0;
    if (!en_s2_r) begin
      state_nxt = ST_OFF; // RULE_14
    end else begin
      case (state_r)
        ST_OFF: begin
          if (!fault_any && !ot_block_r) begin
            state_nxt = ST_RUN;
          end
        end
        ST_RUN: begin
          if (fault_any) begin // RULE_07
            if (latch_hit) begin
              state_nxt = ST_LATCH; // RULE_14
            end else begin
              state_nxt = ST_RETRY;
              rif.start = 1'b1;
            end
          end
        end
        ST_RETRY: begin
          if (rif.done) begin
            if (fault_any || ot_block_r) begin
              rif.start = 1'b1; // RULE_14
            end else begin
              state_nxt = ST_RUN; // RULE_14
            end
          end
        end
        ST_LATCH: state_nxt = ST_LATCH;
        default: state_nxt = ST_OFF;
      endcase
    end
  end

  // State and power stage outputs.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_OFF;
      out_on <= 1'b0;
      turn_off <= 1'b0;
    end else begin
      state_r <= state_nxt;
      out_on <= (state_nxt == ST_RUN);
      turn_off <= (state_r == ST_RUN) && (state_nxt != ST_RUN); // RULE_07
    end
  end

  pfs_retry_timer #(.CYCLES(RETRY_CYCLES)) u_retry (
    .clock(clock),
    .reset_n(reset_n),
    .rif(rif.tmr)
  );

  // Events: fault and warning onsets, and any power good change.
  assign ev = {q[EV_PG] ^ q_d_r[EV_PG], q[EV_PG-1:0] & ~q_d_r[EV_PG-1:0]};

  // Configuration register; its reset value selects the retrying defaults.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cfg_r <= CFG_RESET; // RULE_01 RULE_02 RULE_04
    end else if (reg_wr && (reg_addr == ADDR_CFG)) begin
      cfg_r <= reg_wdata & CFG_WMASK;
    end
  end

  // Sticky interrupt status; a new event wins over a write-one-to-clear.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      q_d_r <= '0;
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      irq <= 1'b0;
    end else begin
      q_d_r <= q;
      if (reg_wr && (reg_addr == ADDR_IRQ_STAT)) begin
        irq_stat_r <= (irq_stat_r & ~reg_wdata) | 32'(ev);
      end else begin
        irq_stat_r <= irq_stat_r | 32'(ev);
      end
      if (reg_wr && (reg_addr == ADDR_IRQ_MASK)) begin
        irq_mask_r <= reg_wdata & 32'((1 << N_EV) - 1);
      end
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // Live status word.
  always_comb begin
    stat_w = '0;
    stat_w[STAT_ON_BIT] = out_on;
    stat_w[STAT_WARN_BIT] = q[EV_WARN]; // RULE_10
    stat_w[STAT_PG_BIT] = q[EV_PG];
    stat_w[STAT_OTBLK_BIT] = ot_block_r;
    stat_w[STAT_STATE_LSB +: 2] = state_r;
  end

  // Read data stand for one cycle only; unmapped offsets read zero.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_CFG: reg_rdata <= cfg_r;
        ADDR_STAT: reg_rdata <= stat_w;
        ADDR_IRQ_STAT: reg_rdata <= irq_stat_r;
        ADDR_IRQ_MASK: reg_rdata <= irq_mask_r;
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // Helper run-length counters, read only by the checks below.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ov_hold_r <= '0;
      warn_hold_r <= '0;
    end else begin
      ov_hold_r <= !raw[EV_OV] ? '0 : (ov_hold_r == '1) ? ov_hold_r : ov_hold_r + 1'b1;
      warn_hold_r <= !raw[EV_WARN] ? '0 : (warn_hold_r == '1) ? warn_hold_r : warn_hold_r + 1'b1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_run_fault;
    state_r == ST_RUN && en_s2_r && fault_any;
  endsequence
  sequence s_off_pulse;
    turn_off && !out_on ##1 !turn_off;
  endsequence

  chk_retry_default: assert property ( // RULE_01
    (s_run_fault and (cfg_r[CFG_LATCH_LSB +: N_FAULT] == '0)) |=> state_r == ST_RETRY)
    else $error("fault without latch select did not enter retry");
  chk_track_gated: assert property ( // RULE_02
    (!cfg_r[CFG_TRK_EN_BIT] && !q[EV_TRK]) |=> !q[EV_TRK])
    else $error("tracking fault qualified while tracking protection disabled");
  chk_oc_range: assert property ( // RULE_03
    oc_thr >= 8'(OC_BASE_PCT) && oc_thr <= 8'(OC_BASE_PCT + OC_STEP_PCT * OC_MAX_CODE))
    else $error("overcurrent threshold outside its range");
  chk_ov_floor: assert property ( // RULE_05
    raw[EV_OV] |-> vout_mv >= 16'(OV_FLOOR_MV) && ov_pct >= 8'(OV_BASE_PCT))
    else $error("overvoltage raised below the voltage floor");
  chk_uv_top: assert property ( // RULE_06
    uv_pct <= 8'(UV_TOP_PCT))
    else $error("undervoltage threshold above its top setting");
  chk_trip_off: assert property ( // RULE_07
    s_run_fault |=> s_off_pulse)
    else $error("fault in run did not give a single turn-off pulse");
  chk_ov_delay: assert property ( // RULE_07
    $rose(q[EV_OV]) |-> ov_hold_r == QUAL_CW'(TRIP_DELAY_CYC))
    else $error("overvoltage qualified after the wrong delay");
  chk_track_ramp: assert property ( // RULE_08
    $rose(q[EV_TRK]) |-> $past(ramp_up) && $past(out_on))
    else $error("tracking fault qualified outside ramp up");
  chk_ot_lock: assert property ( // RULE_09
    (ot_block_r && !q[EV_OT] && temp_c > 10'(OT_ON_C)) |=> ot_block_r ##0 state_r != ST_RUN)
    else $error("overtemperature lock released above the restart level");
  chk_warn_hyst: assert property ( // RULE_10
    (warn_hyst_r && temp_c > 10'(WARN_ON_C - WARN_HYST_C)) |=> warn_hyst_r)
    else $error("warning cleared inside its hysteresis band");
  chk_warn_delay: assert property ( // RULE_11
    $rose(q[EV_WARN]) |-> warn_hold_r == QUAL_CW'(TRIP_DELAY_CYC))
    else $error("warning flag raised after the wrong delay");
  chk_pg_follow: assert property ( // RULE_13
    $changed(power_good_out) |-> power_good_out == $past(raw[EV_PG]))
    else $error("power good moved against its window");
  chk_latch_hold: assert property ( // RULE_14
    (state_r == ST_LATCH && en_s2_r) |=> state_r == ST_LATCH && !out_on)
    else $error("latched fault left latch without re-enable");
  chk_retry_run: assert property ( // RULE_14
    (state_r == ST_RETRY && rif.done && en_s2_r && !fault_any && !ot_block_r)
    |=> state_r == ST_RUN && out_on)
    else $error("retry expiry did not restart the output");
endmodule : pfs_supervisor

// >>> verification/pfs_stage_model.sv
// Behavioural power stage: ramps the output while run, drops it when stopped.
// Assumes the supervisor's clock; the bench sets offset, load, error and ramp speed.
module pfs_stage_model (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Commands from the supervisor and the bench.
  input wire logic out_on,
  input wire logic slow,
  input wire logic [15:0] vset_mv,
  input wire logic signed [15:0] ofs_mv,
  input wire logic [7:0] iset_pct,
  input wire logic signed [15:0] terr_mv,
  // Measurements returned.
  output logic [15:0] vout_mv,
  output logic ramp_up,
  output logic [7:0] iout_pct,
  output logic signed [15:0] track_err_mv
);
  timeunit 1ns;
  timeprecision 1ps;
  logic settled_r;
  logic [15:0] step;

  // A slow ramp keeps the stage ramping long enough for a 6 us qualifier.
  assign step = slow ? 16'h0001 : 16'h0032;

  // The output collapses at once when stopped, which is harsher than a real discharge.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      vout_mv <= 16'h0000;
      ramp_up <= 1'b0;
      settled_r <= 1'b0;
    end else if (!out_on) begin
      vout_mv <= 16'h0000;
      ramp_up <= 1'b0;
      settled_r <= 1'b0;
    end else if (settled_r || vout_mv + step >= vset_mv) begin
      vout_mv <= vset_mv + ofs_mv;
      ramp_up <= 1'b0;
      settled_r <= 1'b1;
    end else begin
      vout_mv <= vout_mv + step;
      ramp_up <= 1'b1;
    end
  end

  // Load current flows only while running; tracking error exists only while ramping.
  assign iout_pct = out_on ? iset_pct : 8'h00;
  assign track_err_mv = ramp_up ? terr_mv : 16'sh0000;
endmodule : pfs_stage_model

// >>> verification/pol_fault_supervisor_bench.sv
// Self-checking bench of the fault supervisor driving a behavioural power stage.
// Assumes a shortened retry period so that the run stays at a little over half the cycle ceiling.
module pol_fault_supervisor_bench import pfs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RETRY = 2000;
  localparam int LIMIT = 100000;
  logic clock;
  logic reset_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic enable_pin = 1'b0;
  logic slow = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [15:0] vset = 16'h09C4;
  logic signed [15:0] ofs = 16'sh0000;
  logic signed [15:0] terr = 16'sh0000;
  logic [7:0] iset = 8'h32;
  logic signed [9:0] temp = 10'sh019;
  logic ramp_up, out_on, turn_off, power_good_out, irq;
  logic [7:0] iout_pct;
  logic [15:0] vout_mv;
  logic signed [15:0] track_err_mv;
  logic [31:0] reg_rdata, rd;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int n;

  pfs_supervisor #(.RETRY_CYCLES(RETRY)) dut (.clock(clock), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .iout_pct(iout_pct), .vout_mv(vout_mv), .vset_mv(vset),
    .temp_c(temp), .track_err_mv(track_err_mv), .ramp_up(ramp_up), .enable_pin(enable_pin),
    .out_on(out_on), .turn_off(turn_off), .power_good_out(power_good_out), .irq(irq));
  pfs_stage_model stage (.clock(clock), .reset_n(reset_n), .out_on(out_on), .slow(slow),
    .vset_mv(vset), .ofs_mv(ofs), .iset_pct(iset), .terr_mv(terr), .vout_mv(vout_mv),
    .ramp_up(ramp_up), .iout_pct(iout_pct), .track_err_mv(track_err_mv));

  // Free-running 100 MHz clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // A hang counts as a mismatch and still ends in the closing report.
  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      close_out();
    end
  end

  // Prints the counts and the verdict, then stops.
  task close_out;
    $display("Comparisons %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  // One comparison; four-state so an unknown never matches.
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Waits n edges and lets their updates land.
  task settle(input int cnt);
    repeat (cnt) @(posedge clock);
    #1;
  endtask : settle

  // Bounded wait for out_on to reach a level; n is the number of edges waited.
  task wait_out(input logic lvl, input int max, output int cnt);
    cnt = 0;
    while (out_on !== lvl && cnt < max) begin
      @(posedge clock);
      #1;
      cnt++;
    end
  endtask : wait_out

  // Single-cycle write strobe.
  task reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : reg_write

  // Single-cycle read strobe; data are taken in the following cycle only.
  task reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read

  // Clean conditions, default config, disabled long enough for every qualifier to clear.
  task recover;
    @(posedge clock);
    ofs <= 16'sh0000;
    terr <= 16'sh0000;
    iset <= 8'h32;
    temp <= 10'sh019;
    vset <= 16'h09C4;
    slow <= 1'b0;
    enable_pin <= 1'b0;
    reg_write(ADDR_CFG, CFG_RESET);
    settle(650);
    @(posedge clock);
    enable_pin <= 1'b1;
    settle(100);
  endtask : recover

  // Applies one set of conditions and judges whether the output survives them.
  task fault_case(input logic [31:0] cfg, input int vs, input int of, input int io,
                  input int tc, input logic exp);
    reg_write(ADDR_CFG, cfg);
    @(posedge clock);
    vset <= 16'(vs);
    ofs <= 16'(of);
    iset <= 8'(io);
    temp <= 10'(tc);
    settle(700);
    chk("out_on under condition", 32'(exp), 32'(out_on));
    recover();
  endtask : fault_case

  // Overvoltage at the default threshold: delay, pulse, event, clear, retry.
  task t_ov_retry;
    reg_write(ADDR_IRQ_MASK, 32'h0000_0002);
    reg_write(ADDR_IRQ_STAT, 32'h0000_007F);
    @(posedge clock);
    ofs <= 16'(749);
    settle(700);
    chk("out_on below ov", 1, 32'(out_on));
    @(posedge clock);
    ofs <= 16'(750);
    wait_out(1'b0, 800, n);
    chk("trip delay in range", 1, 32'(n >= 598 && n <= 604));
    chk("turn_off pulse", 1, 32'(turn_off));
    @(posedge clock);
    ofs <= 16'sh0000;
    settle(2);
    chk("turn_off ends", 0, 32'(turn_off));
    chk("irq raised", 1, 32'(irq));
    reg_write(ADDR_IRQ_STAT, 32'h0000_0002);
    settle(3);
    chk("irq cleared", 0, 32'(irq));
    wait_out(1'b1, 2200, n);
    chk("retry period", 1, 32'(n >= 1900 && n <= 2010));
  endtask : t_ov_retry

  // A latching fault stays off past a retry period until re-enabled.
  task t_latch(input logic [31:0] cfg, input int of, input int io, input int tc);
    reg_write(ADDR_CFG, cfg);
    @(posedge clock);
    ofs <= 16'(of);
    iset <= 8'(io);
    temp <= 10'(tc);
    settle(2700);
    chk("latched off", 0, 32'(out_on));
    reg_read(ADDR_STAT, rd);
    chk("latched state", 3, 32'(rd[9:8]));
    recover();
    chk("re-enabled", 1, 32'(out_on));
  endtask : t_latch

  // Overtemperature trip, restart lock above the turn-on point, release at it.
  task t_ot;
    @(posedge clock);
    temp <= 10'(130);
    settle(700);
    chk("ot trip", 0, 32'(out_on));
    @(posedge clock);
    temp <= 10'(125);
    settle(4500);
    chk("ot lock", 0, 32'(out_on));
    @(posedge clock);
    temp <= 10'(120);
    wait_out(1'b1, 4200, n);
    chk("ot restart", 1, 32'(out_on));
    recover();
  endtask : t_ot

  // Warning flag timing and its hysteresis.
  task t_warn;
    @(posedge clock);
    temp <= 10'(120);
    settle(588);
    reg_read(ADDR_STAT, rd);
    chk("warning early", 0, 32'(rd[STAT_WARN_BIT]));
    settle(20);
    reg_read(ADDR_STAT, rd);
    chk("warning set", 1, 32'(rd[STAT_WARN_BIT]));
    @(posedge clock);
    temp <= 10'(118);
    settle(700);
    reg_read(ADDR_STAT, rd);
    chk("warning held", 1, 32'(rd[STAT_WARN_BIT]));
    @(posedge clock);
    temp <= 10'(117);
    settle(700);
    reg_read(ADDR_STAT, rd);
    chk("warning clear", 0, 32'(rd[STAT_WARN_BIT]));
    recover();
  endtask : t_warn

  // Voltage window bounds, lower bound selection and change delay.
  task t_window;
    @(posedge clock);
    ofs <= -16'sd200;
    settle(700);
    chk("good at 92", 1, 32'(power_good_out));
    reg_write(ADDR_CFG, 32'h0000_1020);
    settle(588);
    chk("good before delay", 1, 32'(power_good_out));
    settle(20);
    chk("bad at 92 of 95", 0, 32'(power_good_out));
    @(posedge clock);
    ofs <= 16'(250);
    settle(700);
    chk("good at 110", 1, 32'(power_good_out));
    @(posedge clock);
    ofs <= 16'(275);
    settle(700);
    chk("bad above 110", 0, 32'(power_good_out));
    recover();
  endtask : t_window

  // Restarts with a slow ramp and a fixed tracking error.
  task trk_run(input logic [31:0] cfg, input int te, input logic exp);
    reg_write(ADDR_CFG, cfg);
    @(posedge clock);
    terr <= 16'(te);
    slow <= 1'b1;
    enable_pin <= 1'b0;
    settle(5);
    @(posedge clock);
    enable_pin <= 1'b1;
    settle(720);
    chk("out_on while ramping", 32'(exp), 32'(out_on));
    recover();
  endtask : trk_run

  // Main sequence.
  initial begin
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    settle(2);
    reg_read(ADDR_CFG, rd);
    chk("cfg reset", CFG_RESET, rd);
    reg_write(ADDR_CFG, 32'hFFFF_FFFF);
    reg_read(ADDR_CFG, rd);
    chk("cfg writable", CFG_WMASK, rd);
    reg_read(8'h10, rd);
    chk("unmapped read", 0, rd);
    reg_write(ADDR_CFG, CFG_RESET);
    @(posedge clock);
    enable_pin <= 1'b1;
    wait_out(1'b1, 10, n);
    chk("power-up delay", 3, n);
    settle(700);
    chk("good after start", 1, 32'(power_good_out));
    t_ov_retry();
    fault_case(32'h0000_0000, 2500, 250, 50, 25, 0);
    fault_case(32'h0000_0010, 2500, 250, 50, 25, 1);
    fault_case(32'h0000_0010, 2500, 500, 50, 25, 0);
    fault_case(32'h0000_0000, 500, 400, 50, 25, 1);
    fault_case(32'h0000_0000, 500, 500, 50, 25, 0);
    fault_case(32'h0000_0020, 2500, 0, 59, 25, 1);
    fault_case(32'h0000_0020, 2500, 0, 60, 25, 0);
    fault_case(32'h0000_002A, 2500, 0, 179, 25, 1);
    fault_case(32'h0000_002A, 2500, 0, 180, 25, 0);
    fault_case(32'h0000_0020, 2500, -400, 50, 25, 0);
    fault_case(32'h0000_0320, 2500, -400, 50, 25, 1);
    fault_case(32'h0000_0020, 2500, 0, 50, 129, 1);
    t_latch(32'h0001_002A, 0, 180, 25);
    t_latch(32'h0002_0020, 750, 50, 25);
    t_latch(32'h0004_0020, -400, 50, 25);
    t_latch(32'h0008_0020, 0, 50, 130);
    t_ot();
    t_warn();
    t_window();
    trk_run(32'h0020_0020, 251, 0);
    trk_run(32'h0020_0020, -251, 0);
    trk_run(32'h0020_0020, 250, 1);
    trk_run(CFG_RESET, 300, 1);
    close_out();
  end
endmodule : pol_fault_supervisor_bench
